// File: pkg/lpac_pkg.sv
package lpac_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_PATTERN_CTRL  = 8'h11;
    localparam logic [7:0] ADDR_FIRST_SCALE   = 8'h12;
    localparam logic [7:0] ADDR_SECOND_SCALE  = 8'h13;
    localparam logic [7:0] ADDR_AUDIO_CTRL    = 8'h2A;

    // ------------------------------------------------------------
    // writable bit masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_PATTERN_CTRL  = 8'h0F;
    localparam logic [7:0] MASK_SCALE         = 8'h3F;
    localparam logic [7:0] MASK_AUDIO_CTRL    = 8'hFF;
    localparam logic [7:0] RESET_PATTERN_CTRL = 8'h00;
    localparam logic [7:0] RESET_SCALE        = 8'h00;
    localparam logic [7:0] RESET_AUDIO_CTRL   = 8'h03;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_BLINK_ENABLE   = 3;
    localparam int BIT_PATTERN_START  = 2;
    localparam int BIT_PATTERN_REPEAT = 1;
    localparam int BIT_INTENSITY_MODE = 0;
    localparam int POS_RED_SCALE      = 4;
    localparam int POS_GREEN_SCALE    = 2;
    localparam int POS_BLUE_SCALE     = 0;
    localparam int POS_GAIN           = 5;
    localparam int BIT_SYNC_MODE      = 4;
    localparam int BIT_AGC_ENABLE     = 3;
    localparam int BIT_SYNC_ENABLE    = 2;
    localparam int POS_INPUT_SEL      = 0;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [1:0] INPUT_SINGLE_ENDED = 2'h0;
    localparam logic [1:0] INPUT_NONE         = 2'h3;
    localparam logic [4:0] GAIN_STEP_DB       = 5'h03;

    typedef enum logic {
        LPAC_SYNC_AMPLITUDE,
        LPAC_SYNC_FREQUENCY
    } lpac_sync_mode_e;

endpackage

// File: hw/lpac_field_decode.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// per-group current scale field splitter
// ------------------------------------------------------------
module lpac_field_decode (
    input  wire logic [7:0] scale_reg_i,
    output logic      [1:0] red_scale_o,
    output logic      [1:0] green_scale_o,
    output logic      [1:0] blue_scale_o
);
    assign red_scale_o   = scale_reg_i[lpac_pkg::POS_RED_SCALE +: 2];
    assign green_scale_o = scale_reg_i[lpac_pkg::POS_GREEN_SCALE +: 2];
    assign blue_scale_o  = scale_reg_i[lpac_pkg::POS_BLUE_SCALE +: 2];
endmodule

// File: hw/lpac_config_regs.sv
`timescale 1ns/1ps
// How it works
// R1: bit 3 of the pattern control register drives the blink start enable output.
// R2: bit 2 of the pattern control register starts the pattern from command one when set.
// R3: bit 1 of the pattern control register picks single run (0) or continuous repeat (1).
// R4: bit 0 of the pattern control register picks intensity mapping mode 0 or 1.
// R5: the first group register holds red, green and blue 2-bit current scale codes.
// R6: the second group register has the same red, green and blue layout.
// R7: gain code in bits 7-5 of the audio register gives 3 dB per step up to 21 dB.
// R8: bit 4 of the audio register picks amplitude (0) or frequency (1) mode.
// R9: bit 3 of the audio register enables automatic gain control.
// R10: bit 2 of the audio register enables audio synchronisation.
// R11: bits 1-0 of the audio register select single-ended input (00) or none (11).
// R12: reserved bits read as zero and ignore writes.
// R13: reset loads zero everywhere except the audio input selector, which loads 11.
module lpac_config_regs (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       wr_en_i,
    input  wire logic       rd_en_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o,
    output logic            blink_enable_o,
    output logic            pattern_start_o,
    output logic            pattern_repeat_o,
    output logic            intensity_mode_o,
    output logic      [1:0] first_red_current_scale_o,
    output logic      [1:0] first_green_current_scale_o,
    output logic      [1:0] first_blue_current_scale_o,
    output logic      [1:0] second_red_current_scale_o,
    output logic      [1:0] second_green_current_scale_o,
    output logic      [1:0] second_blue_current_scale_o,
    output logic      [2:0] gain_code_o,
    output logic      [4:0] gain_db_o,
    output logic            sync_mode_o,
    output logic            agc_enable_o,
    output logic            sync_enable_o,
    output logic      [1:0] input_sel_o,
    output logic            single_ended_audio_pin_sel_o
);

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [7:0] pattern_generator_control;
    logic [7:0] first_group_current_scale;
    logic [7:0] second_group_current_scale;
    logic [7:0] audio_sync_control_one;
    logic [7:0] next_rdata;
    logic [1:0] f_red;
    logic [1:0] f_green;
    logic [1:0] f_blue;
    logic [1:0] s_red;
    logic [1:0] s_green;
    logic [1:0] s_blue;

    // masked write keeps reserved bits at zero
    function automatic logic [7:0] masked(input logic [7:0] v, input logic [7:0] m);
        return v & m;
    endfunction

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pattern_generator_control <= lpac_pkg::RESET_PATTERN_CTRL; // [R13]
        end else if (wr_en_i && addr_i == lpac_pkg::ADDR_PATTERN_CTRL) begin
            pattern_generator_control <= masked(wdata_i, lpac_pkg::MASK_PATTERN_CTRL); // [R12]
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            first_group_current_scale <= lpac_pkg::RESET_SCALE; // [R13]
        end else if (wr_en_i && addr_i == lpac_pkg::ADDR_FIRST_SCALE) begin
            first_group_current_scale <= masked(wdata_i, lpac_pkg::MASK_SCALE); // [R5] [R12]
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            second_group_current_scale <= lpac_pkg::RESET_SCALE; // [R13]
        end else if (wr_en_i && addr_i == lpac_pkg::ADDR_SECOND_SCALE) begin
            second_group_current_scale <= masked(wdata_i, lpac_pkg::MASK_SCALE); // [R6] [R12]
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            audio_sync_control_one <= lpac_pkg::RESET_AUDIO_CTRL; // [R13] [R11]
        end else if (wr_en_i && addr_i == lpac_pkg::ADDR_AUDIO_CTRL) begin
            audio_sync_control_one <= masked(wdata_i, lpac_pkg::MASK_AUDIO_CTRL);
        end
    end

    // ------------------------------------------------------------
    // read mux, unmapped addresses read zero
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = 8'h00;
        unique case (addr_i)
            lpac_pkg::ADDR_PATTERN_CTRL: next_rdata = pattern_generator_control;
            lpac_pkg::ADDR_FIRST_SCALE:  next_rdata = first_group_current_scale;
            lpac_pkg::ADDR_SECOND_SCALE: next_rdata = second_group_current_scale;
            lpac_pkg::ADDR_AUDIO_CTRL:   next_rdata = audio_sync_control_one;
            default:                     next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
        end else if (rd_en_i) begin
            rdata_o <= next_rdata; // [R12]
        end
    end

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    lpac_field_decode u_first (
        .scale_reg_i   (first_group_current_scale),
        .red_scale_o   (f_red),
        .green_scale_o (f_green),
        .blue_scale_o  (f_blue)
    );

    lpac_field_decode u_second (
        .scale_reg_i   (second_group_current_scale),
        .red_scale_o   (s_red),
        .green_scale_o (s_green),
        .blue_scale_o  (s_blue)
    );

    // outputs registered, so they trail the register by one cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            blink_enable_o   <= 1'b0;
            pattern_start_o  <= 1'b0;
            pattern_repeat_o <= 1'b0;
            intensity_mode_o <= 1'b0;
        end else begin
            blink_enable_o   <= pattern_generator_control[lpac_pkg::BIT_BLINK_ENABLE];   // [R1]
            pattern_start_o  <= pattern_generator_control[lpac_pkg::BIT_PATTERN_START];  // [R2]
            pattern_repeat_o <= pattern_generator_control[lpac_pkg::BIT_PATTERN_REPEAT]; // [R3]
            intensity_mode_o <= pattern_generator_control[lpac_pkg::BIT_INTENSITY_MODE]; // [R4]
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            first_red_current_scale_o    <= 2'h0;
            first_green_current_scale_o  <= 2'h0;
            first_blue_current_scale_o   <= 2'h0;
            second_red_current_scale_o   <= 2'h0;
            second_green_current_scale_o <= 2'h0;
            second_blue_current_scale_o  <= 2'h0;
        end else begin
            first_red_current_scale_o    <= f_red;   // [R5]
            first_green_current_scale_o  <= f_green; // [R5]
            first_blue_current_scale_o   <= f_blue;  // [R5]
            second_red_current_scale_o   <= s_red;   // [R6]
            second_green_current_scale_o <= s_green; // [R6]
            second_blue_current_scale_o  <= s_blue;  // [R6]
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            gain_code_o                  <= 3'h0;
            gain_db_o                    <= 5'h00;
            sync_mode_o                  <= lpac_pkg::LPAC_SYNC_AMPLITUDE;
            agc_enable_o                 <= 1'b0;
            sync_enable_o                <= 1'b0;
            input_sel_o                  <= lpac_pkg::INPUT_NONE;
            single_ended_audio_pin_sel_o <= 1'b0;
        end else begin
            gain_code_o   <= audio_sync_control_one[lpac_pkg::POS_GAIN +: 3]; // [R7]
            // 3 dB per step, max 21 fits in five bits
            gain_db_o     <= 5'(audio_sync_control_one[lpac_pkg::POS_GAIN +: 3]
                             * lpac_pkg::GAIN_STEP_DB); // [R7]
            sync_mode_o   <= audio_sync_control_one[lpac_pkg::BIT_SYNC_MODE];   // [R8]
            agc_enable_o  <= audio_sync_control_one[lpac_pkg::BIT_AGC_ENABLE];  // [R9]
            sync_enable_o <= audio_sync_control_one[lpac_pkg::BIT_SYNC_ENABLE]; // [R10]
            input_sel_o   <= audio_sync_control_one[lpac_pkg::POS_INPUT_SEL +: 2]; // [R11]
            // unused codes 01/10 connect nothing, same as 11
            single_ended_audio_pin_sel_o <=
                audio_sync_control_one[lpac_pkg::POS_INPUT_SEL +: 2]
                == lpac_pkg::INPUT_SINGLE_ENDED; // [R11]
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // a write is judged two edges on unless the same register is rewritten at once
    logic wr_pattern;
    logic wr_first;
    logic wr_second;
    logic wr_audio;

    assign wr_pattern = wr_en_i && addr_i == lpac_pkg::ADDR_PATTERN_CTRL;
    assign wr_first   = wr_en_i && addr_i == lpac_pkg::ADDR_FIRST_SCALE;
    assign wr_second  = wr_en_i && addr_i == lpac_pkg::ADDR_SECOND_SCALE;
    assign wr_audio   = wr_en_i && addr_i == lpac_pkg::ADDR_AUDIO_CTRL;

    function automatic logic mapped_addr(input logic [7:0] a);
        return a == lpac_pkg::ADDR_PATTERN_CTRL || a == lpac_pkg::ADDR_FIRST_SCALE
            || a == lpac_pkg::ADDR_SECOND_SCALE || a == lpac_pkg::ADDR_AUDIO_CTRL;
    endfunction

    reserved_zero_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R12]
        pattern_generator_control[7:4] == 4'h0 && first_group_current_scale[7:6] == 2'h0
        && second_group_current_scale[7:6] == 2'h0)
        else $error("reserved bits not zero");

    reset_values_a: assert property (@(posedge clk_i) // [R13]
        $fell(reset_i) |-> audio_sync_control_one == lpac_pkg::RESET_AUDIO_CTRL
        && pattern_generator_control == lpac_pkg::RESET_PATTERN_CTRL
        && first_group_current_scale == lpac_pkg::RESET_SCALE
        && second_group_current_scale == lpac_pkg::RESET_SCALE)
        else $error("reset value wrong");

    // outputs still hold their reset value at the first edge after release
    reset_outputs_a: assert property (@(posedge clk_i) // [R13]
        $fell(reset_i) |-> input_sel_o == lpac_pkg::INPUT_NONE && !single_ended_audio_pin_sel_o
        && !pattern_start_o && !sync_enable_o && gain_code_o == 3'h0)
        else $error("output reset value wrong");

    blink_follow_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R1]
        wr_pattern ##1 !wr_pattern |-> ##1
        blink_enable_o == $past(wdata_i[lpac_pkg::BIT_BLINK_ENABLE], 2))
        else $error("blink enable not following write");

    start_follow_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R2]
        wr_pattern ##1 !wr_pattern |-> ##1
        pattern_start_o == $past(wdata_i[lpac_pkg::BIT_PATTERN_START], 2))
        else $error("pattern start not following write");

    repeat_follow_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R3]
        wr_pattern ##1 !wr_pattern |-> ##1
        pattern_repeat_o == $past(wdata_i[lpac_pkg::BIT_PATTERN_REPEAT], 2))
        else $error("repeat not following write");

    mode_follow_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R4]
        wr_pattern ##1 !wr_pattern |-> ##1
        intensity_mode_o == $past(wdata_i[lpac_pkg::BIT_INTENSITY_MODE], 2))
        else $error("intensity mode not following write");

    first_red_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R5]
        wr_first ##1 !wr_first |-> ##1
        first_red_current_scale_o == $past(wdata_i[lpac_pkg::POS_RED_SCALE +: 2], 2))
        else $error("first red scale wrong");

    first_green_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R5]
        wr_first ##1 !wr_first |-> ##1
        first_green_current_scale_o == $past(wdata_i[lpac_pkg::POS_GREEN_SCALE +: 2], 2))
        else $error("first green scale wrong");

    first_blue_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R5]
        wr_first ##1 !wr_first |-> ##1
        first_blue_current_scale_o == $past(wdata_i[lpac_pkg::POS_BLUE_SCALE +: 2], 2))
        else $error("first blue scale wrong");

    second_red_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R6]
        wr_second ##1 !wr_second |-> ##1
        second_red_current_scale_o == $past(wdata_i[lpac_pkg::POS_RED_SCALE +: 2], 2))
        else $error("second red scale wrong");

    second_green_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R6]
        wr_second ##1 !wr_second |-> ##1
        second_green_current_scale_o == $past(wdata_i[lpac_pkg::POS_GREEN_SCALE +: 2], 2))
        else $error("second green scale wrong");

    second_blue_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R6]
        wr_second ##1 !wr_second |-> ##1
        second_blue_current_scale_o == $past(wdata_i[lpac_pkg::POS_BLUE_SCALE +: 2], 2))
        else $error("second blue scale wrong");

    gain_code_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R7]
        wr_audio ##1 !wr_audio |-> ##1
        gain_code_o == $past(wdata_i[lpac_pkg::POS_GAIN +: 3], 2))
        else $error("gain code not following write");

    // sum rather than product, so the check does not mirror the logic
    gain_db_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R7]
        gain_db_o == {2'h0, gain_code_o} + {2'h0, gain_code_o} + {2'h0, gain_code_o})
        else $error("gain dB not 3 per step");

    audio_bits_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R8] [R9] [R10]
        wr_audio ##1 !wr_audio |-> ##1
        sync_mode_o == $past(wdata_i[lpac_pkg::BIT_SYNC_MODE], 2)
        && agc_enable_o == $past(wdata_i[lpac_pkg::BIT_AGC_ENABLE], 2)
        && sync_enable_o == $past(wdata_i[lpac_pkg::BIT_SYNC_ENABLE], 2))
        else $error("audio control bits wrong");

    input_follow_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R11]
        wr_audio ##1 !wr_audio |-> ##1
        input_sel_o == $past(wdata_i[lpac_pkg::POS_INPUT_SEL +: 2], 2))
        else $error("input select not following write");

    input_sel_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R11]
        single_ended_audio_pin_sel_o == (input_sel_o == lpac_pkg::INPUT_SINGLE_ENDED))
        else $error("input select decode wrong");

    // probing an empty address must not return stale data
    unmapped_read_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R12]
        rd_en_i && !mapped_addr(addr_i) |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");

    unmapped_write_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R12]
        wr_en_i && !mapped_addr(addr_i) |=> $stable(pattern_generator_control)
        && $stable(first_group_current_scale) && $stable(second_group_current_scale)
        && $stable(audio_sync_control_one))
        else $error("unmapped write changed a register");

    // read data stands until the next read strobe
    rdata_hold_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R12]
        !rd_en_i |=> $stable(rdata_o))
        else $error("read data changed without a read");

    reserved_read_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R12]
        rd_en_i && addr_i == lpac_pkg::ADDR_PATTERN_CTRL
        |=> (rdata_o & ~lpac_pkg::MASK_PATTERN_CTRL) == 8'h00)
        else $error("pattern reserved bits read back");

    scale_read_a: assert property (@(posedge clk_i) disable iff (reset_i) // [R12]
        rd_en_i && (addr_i == lpac_pkg::ADDR_FIRST_SCALE
        || addr_i == lpac_pkg::ADDR_SECOND_SCALE)
        |=> (rdata_o & ~lpac_pkg::MASK_SCALE) == 8'h00)
        else $error("scale reserved bits read back");

endmodule

// File: sim/lpac_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// host side of the register port
// ------------------------------------------------------------
module lpac_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic            wr_en_o,
    output logic            rd_en_o,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o
);
    initial begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o  = 8'h00;
        wdata_o = 8'h00;
    end

    // entered just after a rising edge; strobe stays up so back to back calls never
    // assign it twice in one time step
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        wr_en_o = 1'b1;
        rd_en_o = 1'b0;
        addr_o  = addr;
        wdata_o = data;
        @(posedge clk_i);
        #1;
    endtask

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        wr_en_o = 1'b0;
        rd_en_o = 1'b1;
        addr_o  = addr;
        @(posedge clk_i);
        #1;
        data = rdata_i;
    endtask

    // released bus shows inverted values, not the last ones
    task automatic idle();
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o  = ~addr_o;
        wdata_o = ~wdata_o;
        @(posedge clk_i);
        #1;
    endtask
endmodule

// File: sim/test_lpac_config_regs.sv
`timescale 1ns/1ps
module test_lpac_config_regs;
    logic       clk_i = 1'b0;
    logic       reset_i = 1'b1;
    logic       wr_en, rd_en;
    logic [7:0] addr, wdata, rdata, rd;
    logic       blink, start, rpt, imode, smode, agc, sen, pin_sel;
    logic [1:0] r1, g1, b1, r2, g2, b2, isel;
    logic [2:0] gcode;
    logic [4:0] gdb;
    logic [1:0] r, g, b;
    logic [7:0] d;
    int         num_errors = 0;
    int         cmp_count = 0;

    always #50 clk_i = ~clk_i;

    lpac_host_model host (.clk_i(clk_i), .rdata_i(rdata), .wr_en_o(wr_en), .rd_en_o(rd_en),
        .addr_o(addr), .wdata_o(wdata));

    lpac_config_regs dut (.clk_i(clk_i), .reset_i(reset_i), .wr_en_i(wr_en), .rd_en_i(rd_en),
        .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .blink_enable_o(blink),
        .pattern_start_o(start), .pattern_repeat_o(rpt), .intensity_mode_o(imode),
        .first_red_current_scale_o(r1), .first_green_current_scale_o(g1),
        .first_blue_current_scale_o(b1), .second_red_current_scale_o(r2),
        .second_green_current_scale_o(g2), .second_blue_current_scale_o(b2),
        .gain_code_o(gcode), .gain_db_o(gdb), .sync_mode_o(smode), .agc_enable_o(agc),
        .sync_enable_o(sen), .input_sel_o(isel), .single_ended_audio_pin_sel_o(pin_sel));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check_reset();
        host.read_reg(8'h11, rd);
        check("pattern reset", rd, 8'h00);
        host.read_reg(8'h12, rd);
        check("first reset", rd, 8'h00);
        host.read_reg(8'h13, rd);
        check("second reset", rd, 8'h00);
        host.read_reg(8'h2A, rd);
        check("audio reset", rd, 8'h03);
        check("pattern outs reset", {4'h0, blink, start, rpt, imode}, 8'h00);
        check("audio outs reset", {4'h0, smode, agc, sen, pin_sel}, 8'h00);
        check("sel reset", {r1, g1, b1, isel}, 8'h03);
        check("second sel reset", {2'h0, r2, g2, b2}, 8'h00);
        check("gain reset", {gcode, gdb}, 8'h00);
    endtask

    // ------------------------------------------------------------
    // watchdog: the whole sequence needs about 64 cycles, the limit is 2000
    // ------------------------------------------------------------
    initial begin
        #200000;
        num_errors++;
        conclude();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_i);
        #1 reset_i = 1'b0;
        check_reset();
        for (int i = 0; i < 4; i++) begin
            host.write_reg(8'h11, 8'hF0 | (8'h01 << i));
            host.read_reg(8'h11, rd);
            check("pattern read", rd, 8'h01 << i);
            check("pattern out", {4'h0, blink, start, rpt, imode}, 8'h01 << i);
        end
        for (int c = 0; c < 4; c++) begin
            r = 2'(c);
            g = 2'(c + 1);
            b = 2'(c + 2);
            host.write_reg(8'h12, {2'b11, r, g, b});
            host.write_reg(8'h13, {2'b10, b, r, g});
            host.read_reg(8'h12, rd);
            check("first read", rd, {2'b00, r, g, b});
            host.read_reg(8'h13, rd);
            check("second read", rd, {2'b00, b, r, g});
            check("first out", {2'b00, r1, g1, b1}, {2'b00, r, g, b});
            check("second out", {2'b00, r2, g2, b2}, {2'b00, b, r, g});
        end
        for (int i = 0; i < 8; i++) begin
            d = {3'(i), i[0], i[1], i[2], 2'(i)};
            host.write_reg(8'h2A, d);
            host.read_reg(8'h2A, rd);
            check("audio read", rd, d);
            check("audio out", {gcode, smode, agc, sen, isel}, d);
            check("gain db", {3'h0, gdb}, 8'(i * 3));
            check("pin sel", {7'h00, pin_sel}, {7'h00, d[1:0] == 2'b00});
        end
        host.write_reg(8'h14, 8'hFF);
        host.read_reg(8'h14, rd);
        check("unmapped read", rd, 8'h00);
        host.read_reg(8'h13, rd);
        check("second kept", rd, 8'h1C);
        host.idle();
        reset_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #1 reset_i = 1'b0;
        check_reset();
        conclude();
    end
endmodule
